// >>> hdl/umr_device.sv
// Device end: upper mode registers, calibration decode, refresh masks, reset.
// Assumes commands arrive synchronous to sys_clk, one per cycle at most.
`timescale 1ns/1ns
// What this block does
// - Geometry bits 5:2 report read-only density code
// - Geometry bits 7:6 report read-only I/O width
// - Address 09h is vendor test only
// - Code ABh long, 56h short calibration
// - Code FFh init calibration, C3h restores default
// - Controller writes only the four calibration codes
// - Reserved calibration code is ignored entirely
// - Strapped calibration pin ignores all calibration codes
// - No calibration support ignores calibration commands
// - Init calibration may report resistor in register 0
// - Addresses 0Bh to 0Fh are reserved
// - Bank mask: one bit per bank, 1 blocks
// - Four-bank device uses only low four bits
// - Mask bit n controls bank address n
// - Segment mask exists only on 1Gb to 8Gb
// - Segment n selects top three row bits
// - Controller avoids forbidden and reserved address ranges
// - Read of 20h returns pattern A
// - Read of 28h returns pattern B
// - Write to 3Fh resets device, data ignored
module umr_device
    import umr_pkg::*;
#(
    parameter logic [3:0] DENSITY = 4'h5,
    parameter logic [1:0] IO_WIDTH = 2'h0,
    parameter int unsigned NUM_BANKS = 8,
    parameter bit CAL_SUPPORTED = 1'b1,
    parameter logic [7:0] PATTERN_A = 8'h55, // Arbitrary fixed pattern
    parameter logic [7:0] PATTERN_B = 8'h3c, // Arbitrary fixed pattern
    parameter logic [7:0] VENDOR_TEST_VALUE = 8'h00 // Arbitrary value
)(
    input wire logic sys_clk, // 20 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    umr_link_if.dev link, // Mode register command link
    input wire logic cal_pin_strapped, // High: calibration pin tied to core supply
    input wire logic [2:0] refresh_bank, // Bank asked to refresh
    input wire logic [14:0] refresh_row, // Row asked to refresh
    output logic refresh_allowed, // Registered: bank/row may refresh
    output logic cal_start, // Pulse: calibration begins
    output umr_cal_kind_t cal_kind, // Kind of the last calibration
    output logic base_device_info_rzq, // Resistor seen by init calibration
    output logic device_reset // Pulse: reset trigger written
);
    // Elaboration guard: the decode below serves only defined densities,
    // the three defined widths and four- or eight-bank dies
    if (DENSITY > DENS_MAX || IO_WIDTH == 2'h3 || (NUM_BANKS != 4 && NUM_BANKS != 8))
    begin : g_bad_geometry
        $error("umr_device: unsupported geometry");
    end

    logic [7:0] geometry;
    logic [7:0] bank_mask_reg;
    logic [7:0] seg_mask_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic refresh_allowed_reg;
    logic cal_start_reg;
    umr_cal_kind_t cal_kind_reg;
    logic rzq_reg;
    logic device_reset_reg;

    // Geometry is a constant of the die, so no write path reaches it
    assign geometry = {IO_WIDTH, DENSITY, 2'h0};

    // Calibration code to kind; any code outside the four maps to none
    function automatic umr_cal_kind_t cal_code_kind(input logic [7:0] code);
        case (code)
            CAL_INIT: cal_code_kind = CAL_K_INIT;
            CAL_LONG: cal_code_kind = CAL_K_LONG;
            CAL_SHORT: cal_code_kind = CAL_K_SHORT;
            CAL_RESTORE: cal_code_kind = CAL_K_RESTORE;
            default: cal_code_kind = CAL_NONE;
        endcase
    endfunction

    // Top three row bits for the die's density pick the segment
    function automatic logic [2:0] seg_of_row(input logic [14:0] row);
        case (DENSITY)
            DENS_1GB: seg_of_row = row[12:10];
            DENS_8GB: seg_of_row = row[14:12];
            default: seg_of_row = row[13:11];
        endcase
    endfunction

    // Calibration decode; strap or missing support masks every code
    umr_cal_kind_t cal_decoded;
    assign cal_decoded = cal_code_kind(link.op);
    wire cal_hit = link.mrw_valid && link.ma == MA_CAL_CMD;
    wire cal_enabled = CAL_SUPPORTED && !cal_pin_strapped;
    wire code_valid = cal_decoded != CAL_NONE;
    wire is_init = cal_decoded == CAL_K_INIT;
    wire cal_go = cal_hit && cal_enabled && code_valid;

    // Segment mask applies only to 1Gb..8Gb dies
    localparam bit SEG_PRESENT = DENSITY >= DENS_1GB && DENSITY <= DENS_8GB;
    wire [2:0] seg_index = seg_of_row(refresh_row);
    wire seg_blocked = SEG_PRESENT && seg_mask_reg[seg_index];

    // One gate per bank; bits above the die's bank count never block,
    // so a four-bank die ignores the upper half of the mask
    wire [7:0] bank_eff;
    for (genvar g = 0; g < 8; g++)
    begin : g_bank
        assign bank_eff[g] = (g < NUM_BANKS) && bank_mask_reg[g];
    end
    wire bank_blocked = bank_eff[refresh_bank];

    // Write decode per target register
    wire wr_bank = link.mrw_valid && link.ma == MA_BANK_MASK;
    wire wr_seg = SEG_PRESENT && link.mrw_valid && link.ma == MA_SEG_MASK;

    // Read mux; vendor test reads VENDOR_TEST_VALUE, reserved and write-only addresses read zero
    wire [7:0] rd_mux = (link.ma == MA_GEOMETRY) ? geometry :
                        (link.ma == MA_VENDOR_TEST) ? VENDOR_TEST_VALUE :
                        (link.ma == MA_PATTERN_A) ? PATTERN_A :
                        (link.ma == MA_PATTERN_B) ? PATTERN_B :
                        8'h00;

    wire reset_hit = link.mrw_valid && link.ma == MA_RESET;

    // Mask registers; the reset trigger returns them to unmasked too
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || reset_hit)
        begin
            bank_mask_reg <= MASK_RESET;
            seg_mask_reg <= MASK_RESET;
        end
        else
        begin
            if (wr_bank)
                bank_mask_reg <= link.op;
            if (wr_seg)
                seg_mask_reg <= link.op;
        end
    end

    // Calibration start and kind; the reset trigger wipes the kind
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            cal_start_reg <= 1'b0;
            cal_kind_reg <= CAL_NONE;
        end
        else
        begin
            cal_start_reg <= cal_go && !reset_hit;
            if (reset_hit)
                cal_kind_reg <= CAL_NONE;
            else if (cal_go)
                cal_kind_reg <= cal_decoded;
        end
    end

    // Resistor flag: set by the init calibration only, never cleared while running
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            rzq_reg <= 1'b0;
        else if (cal_go && is_init)
            rzq_reg <= 1'b1;
    end

    // Reset trigger pulse; the data byte of the write is never looked at
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            device_reset_reg <= 1'b0;
        else
            device_reset_reg <= reset_hit;
    end

    // Read answer; data stays zero outside an answer so stale bytes never leak
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_valid_reg <= link.mrr_valid;
            rd_data_reg <= link.mrr_valid ? rd_mux : 8'h00;
        end
    end

    // Refresh gate, one cycle behind the bank and row inputs
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            refresh_allowed_reg <= 1'b0;
        else
            refresh_allowed_reg <= !bank_blocked && !seg_blocked;
    end

    assign link.rd_data = rd_data_reg;
    assign link.rd_valid = rd_valid_reg;
    assign refresh_allowed = refresh_allowed_reg;
    assign cal_start = cal_start_reg;
    assign cal_kind = cal_kind_reg;
    assign base_device_info_rzq = rzq_reg;
    assign device_reset = device_reset_reg;
endmodule

// >>> hdl/umr_pkg.sv
// Package for the upper mode-register bank: addresses, field layout, codes.
// Assumes a single 20 MHz clock domain shared by controller and device ends.
package umr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Mode addresses
    localparam logic [7:0] MA_GEOMETRY = 8'h08;
    localparam logic [7:0] MA_VENDOR_TEST = 8'h09;
    localparam logic [7:0] MA_CAL_CMD = 8'h0a;
    localparam logic [7:0] MA_RSVD_LO = 8'h0b;
    localparam logic [7:0] MA_RSVD_HI = 8'h0f;
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_SEG_MASK = 8'h11;
    localparam logic [7:0] MA_PATTERN_A = 8'h20;
    localparam logic [7:0] MA_PATTERN_B = 8'h28;
    localparam logic [7:0] MA_RESET = 8'h3f;
    localparam logic [7:0] MA_FORBID_0 = 8'h7f;
    localparam logic [7:0] MA_FORBID_1 = 8'hbf;
    localparam logic [7:0] MA_FORBID_2 = 8'hff;
    // Geometry field positions
    localparam int unsigned DENS_LSB = 2;
    localparam int unsigned WIDTH_LSB = 6;
    localparam logic [3:0] DENS_1GB = 4'h4;
    localparam logic [3:0] DENS_2GB = 4'h5;
    localparam logic [3:0] DENS_4GB = 4'h6;
    localparam logic [3:0] DENS_8GB = 4'h7;
    localparam logic [3:0] DENS_MAX = 4'h9;
    localparam logic [1:0] IOW_X32 = 2'h0;
    localparam logic [1:0] IOW_X8 = 2'h2;
    // Calibration codes
    localparam logic [7:0] CAL_INIT = 8'hff;
    localparam logic [7:0] CAL_LONG = 8'hab;
    localparam logic [7:0] CAL_SHORT = 8'h56;
    localparam logic [7:0] CAL_RESTORE = 8'hc3;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Controller-side software register offsets
    localparam logic [3:0] CR_ADDR = 4'h0;
    localparam logic [3:0] CR_DATA = 4'h1;
    localparam logic [3:0] CR_CMD = 4'h2;
    localparam logic [3:0] CR_STATUS = 4'h3;
    localparam logic [3:0] CR_RDATA = 4'h4;
    localparam int unsigned CMD_WRITE_BIT = 0;
    localparam int unsigned CMD_READ_BIT = 1;
    typedef enum logic [2:0] {
        CAL_NONE, CAL_K_INIT, CAL_K_LONG, CAL_K_SHORT, CAL_K_RESTORE
    } umr_cal_kind_t;
endpackage

// >>> hdl/umr_link_if.sv
// Interface joining the controller end to the mode-register device end.
// Assumes both ends share sys_clk; read data answer one cycle after a read.
`timescale 1ns/1ns
interface umr_link_if;
    logic mrw_valid; // Mode register write command
    logic mrr_valid; // Mode register read command
    logic [7:0] ma; // Mode address
    logic [7:0] op; // Write data byte
    logic [7:0] rd_data; // Read answer byte
    logic rd_valid; // Read answer strobe
    modport ctrl (output mrw_valid, output mrr_valid, output ma, output op,
                  input rd_data, input rd_valid);
    modport dev (input mrw_valid, input mrr_valid, input ma, input op,
                 output rd_data, output rd_valid);
endinterface

// >>> hdl/umr_controller.sv
// Controller end: software registers turned into mode register commands.
// Assumes the device answers a read exactly one cycle after the command.
`timescale 1ns/1ns
module umr_controller
    import umr_pkg::*;
(
    input wire logic sys_clk, // 20 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    umr_link_if.ctrl link, // Mode register command link
    input wire logic [3:0] sw_addr, // Software register offset
    input wire logic [7:0] sw_wdata, // Software write data
    input wire logic sw_write, // Software write strobe
    input wire logic sw_read, // Software read strobe
    output logic [7:0] sw_rdata, // Read data, one cycle after strobe
    output logic refused // Pulse: command to a forbidden address/code dropped
);
    logic [7:0] ma_reg;
    logic [7:0] op_reg;
    logic mrw_reg;
    logic mrr_reg;
    logic busy_reg;
    logic [7:0] answer_reg;
    logic refused_reg;
    logic refused_sticky_reg;
    logic [7:0] sw_rdata_reg;

    // Forbidden and unavailable ranges are blocked before they reach the link
    wire ma_forbidden = ma_reg == MA_FORBID_0 || ma_reg == MA_FORBID_1 ||
                        ma_reg == MA_FORBID_2 || ma_reg >= 8'h40 ||
                        (ma_reg >= 8'h12 && ma_reg <= 8'h1f) ||
                        (ma_reg >= 8'h21 && ma_reg <= 8'h27) ||
                        (ma_reg >= 8'h29 && ma_reg <= 8'h3e) ||
                        (ma_reg >= MA_RSVD_LO && ma_reg <= MA_RSVD_HI) ||
                        ma_reg == MA_VENDOR_TEST;
    wire op_bad = ma_reg == MA_CAL_CMD && !(op_reg == CAL_INIT ||
                  op_reg == CAL_LONG || op_reg == CAL_SHORT ||
                  op_reg == CAL_RESTORE);
    wire cmd_hit = sw_write && sw_addr == CR_CMD;
    wire want_wr = cmd_hit && sw_wdata[CMD_WRITE_BIT];
    wire want_rd = cmd_hit && !sw_wdata[CMD_WRITE_BIT] && sw_wdata[CMD_READ_BIT];
    wire drop = (want_wr && (ma_forbidden || op_bad)) || (want_rd && ma_forbidden);
    wire [7:0] status = {6'h00, refused_sticky_reg, busy_reg};
    wire [7:0] rd_sel = (sw_addr == CR_ADDR) ? ma_reg :
                        (sw_addr == CR_DATA) ? op_reg :
                        (sw_addr == CR_STATUS) ? status :
                        (sw_addr == CR_RDATA) ? answer_reg : 8'h00;

    // Software registers and command launch
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ma_reg <= 8'h00;
            op_reg <= 8'h00;
            mrw_reg <= 1'b0;
            mrr_reg <= 1'b0;
            refused_reg <= 1'b0;
        end
        else
        begin
            if (sw_write && sw_addr == CR_ADDR)
                ma_reg <= sw_wdata;
            if (sw_write && sw_addr == CR_DATA)
                op_reg <= sw_wdata;
            mrw_reg <= want_wr && !drop && !busy_reg;
            mrr_reg <= want_rd && !drop && !busy_reg;
            refused_reg <= drop;
        end
    end

    // Read answer capture; set wins over a status clear
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            busy_reg <= 1'b0;
            answer_reg <= 8'h00;
            refused_sticky_reg <= 1'b0;
            sw_rdata_reg <= 8'h00;
        end
        else
        begin
            if (mrr_reg)
                busy_reg <= 1'b1;
            else if (link.rd_valid)
                busy_reg <= 1'b0;
            if (link.rd_valid)
                answer_reg <= link.rd_data;
            if (drop)
                refused_sticky_reg <= 1'b1;
            else if (sw_write && sw_addr == CR_STATUS && sw_wdata[1])
                refused_sticky_reg <= 1'b0;
            sw_rdata_reg <= sw_read ? rd_sel : 8'h00;
        end
    end

    assign link.ma = ma_reg;
    assign link.op = op_reg;
    assign link.mrw_valid = mrw_reg;
    assign link.mrr_valid = mrr_reg;
    assign sw_rdata = sw_rdata_reg;
    assign refused = refused_reg;
endmodule

// >>> dv/umr_link_monitor.sv
// Checker on the link between controller and device ends.
// Assumes it sits beside the link interface, one clock domain.
`timescale 1ns/1ns
module umr_link_monitor
    import umr_pkg::*;
#(
    parameter logic [3:0] DENSITY = 4'h5,
    parameter logic [1:0] IO_WIDTH = 2'h0,
    parameter logic [7:0] PATTERN_A = 8'h55,
    parameter logic [7:0] PATTERN_B = 8'h3c
)(
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Sync reset, active low
    input wire logic mrw_valid, // Write command
    input wire logic mrr_valid, // Read command
    input wire logic [7:0] ma, // Mode address
    input wire logic [7:0] op, // Write byte
    input wire logic [7:0] rd_data, // Answer byte
    input wire logic rd_valid // Answer strobe
);
    // Addresses and codes the controller may put on the link
    wire ma_ok;
    wire cal_ok;
    wire cmd;
    assign ma_ok = ma inside {MA_GEOMETRY, MA_CAL_CMD, MA_BANK_MASK, MA_SEG_MASK,
        MA_PATTERN_A, MA_PATTERN_B, MA_RESET};
    assign cal_ok = op inside {CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESTORE};
    assign cmd = mrw_valid || mrr_valid;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd(a);
        mrr_valid && ma == a;
    endsequence
    property p_cmd_addr; cmd |-> ma_ok; endproperty
    a_cmd_addr: assert property (p_cmd_addr) else $error("command to reserved address");
    property p_vendor; cmd |-> ma != MA_VENDOR_TEST; endproperty
    a_vendor: assert property (p_vendor) else $error("vendor test address used");
    property p_cal_code; mrw_valid && ma == MA_CAL_CMD |-> cal_ok; endproperty
    a_cal_code: assert property (p_cal_code) else $error("bad calibration code");
    property p_pat_a; s_rd(MA_PATTERN_A) |=> rd_valid && rd_data == PATTERN_A; endproperty
    a_pat_a: assert property (p_pat_a) else $error("pattern A wrong");
    property p_pat_b; s_rd(MA_PATTERN_B) |=> rd_valid && rd_data == PATTERN_B; endproperty
    a_pat_b: assert property (p_pat_b) else $error("pattern B wrong");
    property p_dens; s_rd(MA_GEOMETRY) |=> rd_data[5:2] == DENSITY; endproperty
    a_dens: assert property (p_dens) else $error("density field wrong");
    property p_width; s_rd(MA_GEOMETRY) |=> rd_data[7:6] == IO_WIDTH; endproperty
    a_width: assert property (p_width) else $error("width field wrong");
    property p_answer; rd_valid |-> $past(mrr_valid); endproperty
    a_answer: assert property (p_answer) else $error("answer without read");
    // Main scenarios reached
    c_cal: cover property (mrw_valid && ma == MA_CAL_CMD);
    c_pat: cover property (s_rd(MA_PATTERN_B));
    c_rst: cover property (mrw_valid && ma == MA_RESET);
endmodule

// >>> dv/sdram_upper_mode_registers_tb_top.sv
// Bench: controller and device joined, plus a lone device driven raw.
// Assumes the umr package and a single 20 MHz clock.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module sdram_upper_mode_registers_tb_top;
    import umr_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cal_pin_strapped = 1'b0;
    logic [2:0] refresh_bank = 3'h0;
    logic [14:0] refresh_row = 15'h0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_write = 1'b0;
    logic sw_read = 1'b0;
    logic [7:0] rd;
    wire [7:0] sw_rdata;
    wire refused, allowed, allowed_b, cal_start, cal_start_b, rzq, dev_rst;
    umr_cal_kind_t cal_kind;
    int n_mismatch = 0, n_checks = 0, n_cal = 0, n_cal_b = 0, n_rst = 0, n_ref = 0;
    int cycles = 0, seed = 58, bm, sm, v;
    logic [7:0] codes[4] = '{CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESTORE};
    umr_cal_kind_t kinds[4] = '{CAL_K_INIT, CAL_K_LONG, CAL_K_SHORT, CAL_K_RESTORE};
    logic [7:0] bad[8] = '{8'h09, 8'h0b, 8'h0f, 8'h12, 8'h21, 8'h3e, 8'h7f, 8'hff};
    umr_link_if i_umr_link_if();
    umr_link_if i_umr_link_if_b();
    umr_controller i_umr_controller (.sys_clk(sys_clk), .reset_n(reset_n),
        .link(i_umr_link_if.ctrl), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
        .sw_read(sw_read), .sw_rdata(sw_rdata), .refused(refused));
    umr_device #(.DENSITY(DENS_2GB), .IO_WIDTH(IOW_X32)) i_umr_device (
        .sys_clk(sys_clk), .reset_n(reset_n), .link(i_umr_link_if.dev),
        .cal_pin_strapped(cal_pin_strapped), .refresh_bank(refresh_bank),
        .refresh_row(refresh_row), .refresh_allowed(allowed), .cal_start(cal_start),
        .cal_kind(cal_kind), .base_device_info_rzq(rzq), .device_reset(dev_rst));
    // Lone 512Mb four-bank die: takes what a careless controller might send
    umr_device #(.DENSITY(4'h3), .NUM_BANKS(4)) i_umr_device_b (.sys_clk(sys_clk),
        .reset_n(reset_n), .link(i_umr_link_if_b.dev), .cal_pin_strapped(cal_pin_strapped),
        .refresh_bank(refresh_bank), .refresh_row(refresh_row), .refresh_allowed(allowed_b),
        .cal_start(cal_start_b), .cal_kind(), .base_device_info_rzq(), .device_reset());
    umr_link_monitor #(.DENSITY(DENS_2GB)) i_umr_link_monitor (.sys_clk(sys_clk),
        .reset_n(reset_n),
        .mrw_valid(i_umr_link_if.mrw_valid), .mrr_valid(i_umr_link_if.mrr_valid),
        .ma(i_umr_link_if.ma), .op(i_umr_link_if.op), .rd_data(i_umr_link_if.rd_data),
        .rd_valid(i_umr_link_if.rd_valid));
    initial forever #25 sys_clk = ~sys_clk;
    // Pulse counters and hang guard; the run should need under 3000 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cal_start === 1'b1) n_cal++;
        if (cal_start_b === 1'b1) n_cal_b++;
        if (dev_rst === 1'b1) n_rst++;
        if (refused === 1'b1) n_ref++;
        if (cycles == 8000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge sys_clk);
        sw_write <= 1'b0;
    endtask
    task automatic mr_wr(input logic [7:0] a, input logic [7:0] d);
        sw_wr(CR_ADDR, a);
        sw_wr(CR_DATA, d);
        sw_wr(CR_CMD, 8'h01);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic sw_rd(input logic [3:0] a);
        @(posedge sys_clk);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge sys_clk);
        sw_read <= 1'b0;
        #1 rd = sw_rdata;
    endtask
    task automatic mr_rd(input logic [7:0] a);
        sw_wr(CR_ADDR, a);
        sw_wr(CR_CMD, 8'h02);
        repeat (2) @(posedge sys_clk);
        sw_rd(CR_RDATA);
    endtask
    // Raw write on the lone link, held until the sampling edge
    task automatic lone_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        i_umr_link_if_b.ma <= a;
        i_umr_link_if_b.op <= d;
        i_umr_link_if_b.mrw_valid <= 1'b1;
        @(posedge sys_clk);
        i_umr_link_if_b.mrw_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // Reference: bank bit blocks when it exists, segment only on 1Gb to 8Gb
    function automatic logic exp_ok(int b, int r, int bk, int sg, int dens, int nb);
        int seg;
        seg = (dens == 4) ? (r >> 10) & 7 : (dens == 7) ? (r >> 12) & 7 : (r >> 11) & 7;
        exp_ok = !(b < nb && bk[b]) && !(dens >= 4 && dens <= 7 && sg[seg]);
    endfunction
    task automatic chk_ref(input int bk, input int sg, input int bkb, input int sgb);
        @(posedge sys_clk);
        refresh_bank <= 3'($random(seed));
        refresh_row <= 15'($random(seed));
        @(posedge sys_clk);
        #1;
        `CHK(allowed, exp_ok(refresh_bank, refresh_row, bk, sg, 5, 8))
        `CHK(allowed_b, exp_ok(refresh_bank, refresh_row, bkb, sgb, 3, 4))
    endtask
    initial
    begin
        i_umr_link_if_b.mrw_valid = 1'b0;
        i_umr_link_if_b.mrr_valid = 1'b0;
        i_umr_link_if_b.ma = 8'h00;
        i_umr_link_if_b.op = 8'h00;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        mr_rd(MA_GEOMETRY);
        `CHK(rd, {IOW_X32, DENS_2GB, 2'b00})
        mr_wr(MA_GEOMETRY, 8'hff);
        mr_rd(MA_GEOMETRY);
        `CHK(rd, {IOW_X32, DENS_2GB, 2'b00})
        mr_rd(MA_PATTERN_A);
        `CHK(rd, 8'h55)
        mr_rd(MA_PATTERN_B);
        `CHK(rd, 8'h3c)
        $display("read tests done");
        foreach (codes[i])
        begin
            v = n_cal;
            mr_wr(MA_CAL_CMD, codes[i]);
            `CHK(n_cal, v + 1)
            `CHK(cal_kind, kinds[i])
        end
        `CHK(rzq, 1'b1)
        v = n_ref;
        mr_wr(MA_CAL_CMD, 8'h12);
        `CHK(n_ref, v + 1)
        cal_pin_strapped <= 1'b1;
        v = n_cal;
        mr_wr(MA_CAL_CMD, CAL_LONG);
        `CHK(n_cal, v)
        cal_pin_strapped <= 1'b0;
        foreach (bad[i])
        begin
            v = n_ref;
            mr_wr(bad[i], 8'h00);
            `CHK(n_ref, v + 1)
        end
        sw_rd(CR_STATUS);
        `CHK(rd, 8'h02)
        sw_wr(CR_STATUS, 8'h02);
        sw_rd(CR_STATUS);
        `CHK(rd, 8'h00)
        v = n_cal_b;
        lone_wr(MA_CAL_CMD, 8'h12);
        `CHK(n_cal_b, v)
        lone_wr(MA_CAL_CMD, CAL_SHORT);
        `CHK(n_cal_b, v + 1)
        $display("calibration tests done");
        repeat (24)
        begin
            bm = $random(seed) & 255;
            sm = $random(seed) & 255;
            mr_wr(MA_BANK_MASK, 8'(bm));
            mr_wr(MA_SEG_MASK, 8'(sm));
            lone_wr(MA_BANK_MASK, 8'(bm));
            lone_wr(MA_SEG_MASK, 8'(sm));
            repeat (4) chk_ref(bm, sm, bm, sm);
        end
        $display("mask tests done");
        v = n_rst;
        mr_wr(MA_RESET, 8'($random(seed)));
        `CHK(n_rst, v + 1)
        `CHK(cal_kind, CAL_NONE)
        repeat (4) chk_ref(0, 0, bm, sm);
        $display("reset tests done");
        print_verdict();
    end
endmodule
